// ---- common/timer_consts.svh ----
// register indices, field positions, reset values and divider counts of the timer source block
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_TIMER_1        8'h21
`define IDX_TIMER_2        8'h22
`define IDX_MODE_CTRL      8'h23
`define IDX_TIMER_X        8'h25
`define IDX_TIMER_Y        8'h27
`define IDX_SRC_SELECT     8'h28
`define IDX_REQ_STATUS     8'h30
`define IDX_IRQ_ENABLE_ONE 8'h3e

// source select fields
`define SRC_X_BIT          0
`define SRC_Y_BIT          1
`define SRC_T12_BIT        2
`define SRC_IMPL_WIDTH     3

// mode control fields, timer x in the low nibble, timer y in the high nibble
`define MODE_Y_BASE        4
`define MODE_EDGE_OFS      2
`define MODE_STOP_OFS      3

// reset values
`define SRC_RESET          3'h0
`define IRQ_ENABLE_RESET   8'h00
`define MODE_RESET         8'h00
`define LATCH_RESET        8'hff
`define REQ_RESET          4'h0
`define PIN_OUT_RESET      2'h3

// oscillator pre-divider: divide by 16 and by 2
`define PREDIV_LAST        4'hf

// channel numbering
`define CH_X               0
`define CH_Y               1
`define CH_1               2
`define CH_2               3
`define NUM_CH             4

`endif

// ---- common/timer_pkg.sv ----
// types shared by the timer source block and its counter channels
package timer_pkg;

    // operating mode of timer x and timer y, in field order
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_PULSE_OUT,
        MODE_EVENT_COUNT,
        MODE_WIDTH_MEASURE
    } timer_mode_t;

    // bus address phase held for the data phase
    typedef struct packed {
        logic       valid;
        logic       wr;
        logic       hit;
        logic [7:0] idx;
    } bus_req_t;

endpackage : timer_pkg

// ---- core/timer_down_channel.sv ----
// one 8-bit down counter with reload latch and underflow pulse
`timescale 1ns/10ps
`include "timer_consts.svh"

module timer_down_channel
    import timer_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             tick,
    input  wire logic             stop,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] count_r,
    output logic                  underflow_r
);

    logic [WIDTH-1:0] latch_r;
    logic [WIDTH-1:0] latch_nxt;
    logic [WIDTH-1:0] count_nxt;
    logic             underflow_nxt;

    // a write fills latch and counter together; a tick at zero reloads from the latch
    always_comb
    begin
        latch_nxt     = latch_r;
        count_nxt     = count_r;
        underflow_nxt = 1'b0;
        if (load)
        begin
            latch_nxt = load_value;
            count_nxt = load_value;
        end
        else if (tick && !stop)
        begin
            if (count_r == '0)
            begin
                count_nxt     = latch_r;
                underflow_nxt = 1'b1;
            end
            else
            begin
                count_nxt = count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            latch_r     <= `LATCH_RESET;
            count_r     <= `LATCH_RESET;
            underflow_r <= 1'b0;
        end
        else
        begin
            latch_r     <= latch_nxt;
            count_r     <= count_nxt;
            underflow_r <= underflow_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence tick_at_zero;
        tick && !stop && !load && count_r == '0;
    endsequence

    AST_RELOAD_ON_UNDERFLOW: assert property (
        tick_at_zero |=> (count_r == $past(latch_r)) && underflow_r)
        else $error("counter did not reload from latch on underflow");

    AST_STOP_HOLDS: assert property (
        (stop && !load) |=> (count_r == $past(count_r)) && !underflow_r)
        else $error("stopped counter changed");

    AST_DECREMENT: assert property (
        (tick && !stop && !load && count_r != '0) |=> count_r == $past(count_r) - 1'b1)
        else $error("counter did not step down by one");

endmodule : timer_down_channel

// ---- core/timer_source_select_and_irq_enable.sv ----
// timer count source selection, timer x/y modes and interrupt enables behind an ahb-lite slave
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "timer_consts.svh"

// Function
// - source bit 0: timer x from oscillator /16 at 0, /2 at 1
// - source bit 1: timer y from oscillator /16 at 0, /2 at 1
// - source bit 2: timers 1/2 from oscillator /16 at 0, raw sub oscillator at 1
// - source bits 3 to 7 ignore writes and read zero
// - enable bit 6 is timer x interrupt, bit 7 timer y, reset zero
// - enable bits 0 to 5 gate external, line, and bus-unit interrupts
// - each timer requests an interrupt when its count elapses
// - underflow reloads the counter from its latch and keeps counting
// - pulse output mode toggles the timer pin at every underflow
// - event mode counts edges on the timer pin
// - width mode counts only while the pin sits at the chosen level
// - mode field: 00 timer, 01 pulse, 10 event, 11 width
// - stop bit at 1 halts counting, resets to 0
// - edge bit picks start level, counted edge or measured level by mode
module timer_source_select_and_irq_enable
    import timer_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        low_speed_mode,
    input  wire logic        main_osc_in,
    input  wire logic        sub_osc_in,
    input  wire logic        timer_x_io_pin_in,
    output logic             timer_x_io_pin_out,
    output logic             timer_x_io_pin_oe,
    input  wire logic        timer_y_io_pin_in,
    output logic             timer_y_io_pin_out,
    output logic             timer_y_io_pin_oe,
    output logic [3:0]       timer_irq_req,
    output logic [7:0]       interrupt_enable_one
);

    localparam int NSYNC = 4;

    // pin synchronisers: main osc, sub osc, timer x pin, timer y pin
    logic [NSYNC-1:0] sync1_r, sync1_nxt;
    logic [NSYNC-1:0] sync2_r, sync2_nxt;
    logic [NSYNC-1:0] prev_r,  prev_nxt;
    logic [NSYNC-1:0] rise, fall;

    // registers
    bus_req_t                    req_r, req_nxt;
    logic [31:0]                 hrdata_nxt;
    logic [`SRC_IMPL_WIDTH-1:0]  src_r, src_nxt;
    logic [7:0]                  ie_r, ie_nxt;
    logic [7:0]                  mode_r, mode_nxt;
    logic [`NUM_CH-1:0]          reqst_r, reqst_nxt;
    logic [3:0]                  prediv_r, prediv_nxt;
    logic [1:0]                  pin_out_r, pin_out_nxt;
    logic [1:0]                  pin_oe_r, pin_oe_nxt;

    // channel wiring
    logic [`NUM_CH-1:0]          ch_tick, ch_stop, ch_load, ch_uf;
    logic [WIDTH-1:0]            ch_count [`NUM_CH];
    logic                        osc_edge, slow_tick, fast_tick;
    logic                        take, wr_en;

    // sample every pin twice before use; the third stage feeds edge detection only
    always_comb
    begin
        sync1_nxt = {timer_y_io_pin_in, timer_x_io_pin_in, sub_osc_in, main_osc_in};
        sync2_nxt = sync1_r;
        prev_nxt  = sync2_r;
        rise      = sync2_r & ~prev_r;
        fall      = ~sync2_r & prev_r;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r  <= prev_nxt;
        end
    end

    // one pre-divider on the active oscillator; low-speed mode swaps in the sub oscillator
    always_comb
    begin
        osc_edge   = low_speed_mode ? rise[1] : rise[0];
        prediv_nxt = osc_edge ? prediv_r + 1'b1 : prediv_r;
        slow_tick  = osc_edge && (prediv_r == `PREDIV_LAST);
        fast_tick  = osc_edge && prediv_r[0];
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            prediv_r <= '0;
        else
            prediv_r <= prediv_nxt;
    end

    // per-channel count source, stop and load; timers 1/2 have no stop bit
    generate
        for (genvar c = 0; c < `NUM_CH; c++)
        begin : g_ch
            localparam logic [7:0] IDX = (c == `CH_X) ? `IDX_TIMER_X :
                                         (c == `CH_Y) ? `IDX_TIMER_Y :
                                         (c == `CH_1) ? `IDX_TIMER_1 : `IDX_TIMER_2;
            logic        src_tick;
            logic        edge_bit;
            timer_mode_t mode;

            if (c < 2)
            begin : g_xy
                localparam int B = (c == `CH_X) ? 0 : `MODE_Y_BASE;
                assign mode        = timer_mode_t'(mode_r[B+1:B]);
                assign edge_bit    = mode_r[B+`MODE_EDGE_OFS];
                assign src_tick    = src_r[c] ? fast_tick : slow_tick;
                assign ch_stop[c]  = mode_r[B+`MODE_STOP_OFS];
                // edge bit: counted edge in event mode, measured level in width mode
                assign ch_tick[c]  =
                    (mode == MODE_EVENT_COUNT) ? (edge_bit ? fall[c+2] : rise[c+2]) :
                    (mode == MODE_WIDTH_MEASURE) ?
                        (src_tick && (sync2_r[c+2] == !edge_bit)) :
                    src_tick;
            end
            else
            begin : g_12
                assign mode        = MODE_TIMER;
                assign edge_bit    = 1'b0;
                assign src_tick    = src_r[`SRC_T12_BIT] ? rise[1] : slow_tick;
                assign ch_stop[c]  = 1'b0;
                assign ch_tick[c]  = src_tick;
            end

            assign ch_load[c] = wr_en && (req_r.idx == IDX);

            timer_down_channel #(
                .WIDTH       (WIDTH)
            ) u_chan (
                .clock       (clock),
                .reset       (reset),
                .tick        (ch_tick[c]),
                .stop        (ch_stop[c]),
                .load        (ch_load[c]),
                .load_value  (hwdata[WIDTH-1:0]),
                .count_r     (ch_count[c]),
                .underflow_r (ch_uf[c])
            );
        end
    endgenerate

    // pin drive: start level while stopped, toggle on each underflow in pulse mode
    always_comb
    begin
        pin_out_nxt = pin_out_r;
        pin_oe_nxt  = '0;
        for (int p = 0; p < 2; p++)
        begin
            pin_oe_nxt[p] = (mode_nxt[p*`MODE_Y_BASE +: 2] == MODE_PULSE_OUT);
            if (!pin_oe_nxt[p] || ch_stop[p])
                pin_out_nxt[p] = !mode_nxt[p*`MODE_Y_BASE + `MODE_EDGE_OFS];
            else if (ch_uf[p])
                pin_out_nxt[p] = !pin_out_r[p];
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pin_out_r <= `PIN_OUT_RESET;
            pin_oe_r  <= '0;
        end
        else
        begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    // ahb-lite slave: zero wait states, writes land in the data phase
    always_comb
    begin
        take        = hsel && htrans[1] && hready;
        req_nxt     = '{valid: take, wr: hwrite, hit: (haddr[31:10] == '0),
                        idx: haddr[9:2]};
        wr_en       = req_r.valid && req_r.wr && req_r.hit;
        src_nxt     = src_r;
        ie_nxt      = ie_r;
        mode_nxt    = mode_r;
        reqst_nxt   = reqst_r;
        if (wr_en)
        begin
            if (req_r.idx == `IDX_SRC_SELECT)
                src_nxt = hwdata[`SRC_IMPL_WIDTH-1:0];
            else if (req_r.idx == `IDX_IRQ_ENABLE_ONE)
                ie_nxt = hwdata[7:0];
            else if (req_r.idx == `IDX_MODE_CTRL)
                mode_nxt = hwdata[7:0];
            else if (req_r.idx == `IDX_REQ_STATUS)
                reqst_nxt = reqst_r & ~hwdata[`NUM_CH-1:0];      // write one to clear
        end
        reqst_nxt = reqst_nxt | ch_uf;                           // set wins over clear
        // control and status reads use next values so a write followed at once by a read returns new data
        hrdata_nxt = hrdata;
        if (take && !hwrite)
        begin
            hrdata_nxt = '0;
            if (haddr[31:10] != '0)
                hrdata_nxt = '0;
            else if (haddr[9:2] == `IDX_SRC_SELECT)
                hrdata_nxt[`SRC_IMPL_WIDTH-1:0] = src_nxt;
            else if (haddr[9:2] == `IDX_IRQ_ENABLE_ONE)
                hrdata_nxt[7:0] = ie_nxt;
            else if (haddr[9:2] == `IDX_MODE_CTRL)
                hrdata_nxt[7:0] = mode_nxt;
            else if (haddr[9:2] == `IDX_REQ_STATUS)
                hrdata_nxt[`NUM_CH-1:0] = reqst_nxt;
            else if (haddr[9:2] == `IDX_TIMER_X)
                hrdata_nxt[WIDTH-1:0] = ch_count[`CH_X];
            else if (haddr[9:2] == `IDX_TIMER_Y)
                hrdata_nxt[WIDTH-1:0] = ch_count[`CH_Y];
            else if (haddr[9:2] == `IDX_TIMER_1)
                hrdata_nxt[WIDTH-1:0] = ch_count[`CH_1];
            else if (haddr[9:2] == `IDX_TIMER_2)
                hrdata_nxt[WIDTH-1:0] = ch_count[`CH_2];
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            req_r     <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            src_r     <= `SRC_RESET;
            ie_r      <= `IRQ_ENABLE_RESET;
            mode_r    <= `MODE_RESET;
            reqst_r   <= `REQ_RESET;
        end
        else
        begin
            req_r     <= req_nxt;
            hrdata    <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            src_r     <= src_nxt;
            ie_r      <= ie_nxt;
            mode_r    <= mode_nxt;
            reqst_r   <= reqst_nxt;
        end
    end

    // underflow pulses leave straight from the channel flops
    assign timer_irq_req        = ch_uf;
    assign interrupt_enable_one = ie_r;
    assign timer_x_io_pin_out   = pin_out_r[0];
    assign timer_x_io_pin_oe    = pin_oe_r[0];
    assign timer_y_io_pin_out   = pin_out_r[1];
    assign timer_y_io_pin_oe    = pin_oe_r[1];

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence read_src;
        take && !hwrite && haddr[31:2] == {22'h0, `IDX_SRC_SELECT};
    endsequence

    AST_SRC_HIGH_ZERO: assert property (
        read_src |=> hrdata[7:`SRC_IMPL_WIDTH] == '0)
        else $error("unimplemented source bits read nonzero");

    AST_SRC_RESET: assert property (
        $fell(reset) |-> src_r == '0)
        else $error("source select not zero after reset");

    AST_X_FAST_SOURCE: assert property (
        (src_r[0] && mode_r[1:0] == 2'h0 && !ch_stop[0] && fast_tick && !ch_load[0]
         && ch_count[0] != '0) |=> ch_count[0] == $past(ch_count[0]) - 1'b1)
        else $error("timer x missed a divide-by-2 tick");

    AST_Y_SLOW_ONLY: assert property (
        (!src_r[1] && mode_r[5:4] == 2'h0 && !slow_tick && !ch_load[1])
        |=> ch_count[1] == $past(ch_count[1]))
        else $error("timer y moved without a divide-by-16 tick");

    AST_IE_WRITE: assert property (
        (wr_en && req_r.idx == `IDX_IRQ_ENABLE_ONE) |=> ie_r == $past(hwdata[7:0]))
        else $error("enable register did not take written value");

    AST_REQ_STICKY: assert property (
        ch_uf[0] |=> reqst_r[0])
        else $error("timer x underflow left no request");

    AST_PULSE_TOGGLE: assert property (
        (pin_oe_r[0] && mode_nxt[1:0] == 2'h1 && !ch_stop[0] && ch_uf[0])
        |=> timer_x_io_pin_out != $past(timer_x_io_pin_out))
        else $error("timer x pin did not toggle on underflow");

    AST_WIDTH_GATE: assert property (
        (mode_r[1:0] == 2'h3 && sync2_r[2] == mode_r[2] && !ch_load[0])
        |=> ch_count[0] == $past(ch_count[0]))
        else $error("width mode counted at the wrong pin level");

    AST_EVENT_EDGE: assert property (
        (mode_r[5:4] == 2'h2 && !ch_stop[1] && !ch_load[1] && ch_count[1] != '0
         && (mode_r[6] ? fall[3] : rise[3])) |=> ch_count[1] == $past(ch_count[1]) - 1'b1)
        else $error("event mode missed a pin edge");

endmodule : timer_source_select_and_irq_enable

// ---- verification/timer_pin_source.sv ----
// oscillators and external pulse source standing outside the timer block
`timescale 1ns/10ps

module timer_pin_source
(
    input  wire logic x_level,
    input  wire logic y_level,
    input  wire logic x_out,
    input  wire logic x_oe,
    input  wire logic y_out,
    input  wire logic y_oe,
    output logic      main_osc,
    output logic      sub_osc,
    output wire       x_wire,
    output wire       y_wire
);
    // free-running crystals, phase kept off the system clock edges
    initial
    begin
        main_osc = 1'b0;
        sub_osc  = 1'b0;
        #37;
        fork
            forever #200 main_osc = ~main_osc;
            forever #300 sub_osc = ~sub_osc;
        join
    end

    // the source lets go of a pin while the block drives it
    assign x_wire = x_oe ? x_out : x_level;
    assign y_wire = y_oe ? y_out : y_level;
endmodule : timer_pin_source

// ---- verification/timer_source_select_and_irq_enable_test.sv ----
// self-checking bench: register bus, timer periods, pulse, event and width modes
`timescale 1ns/10ps
`include "timer_consts.svh"

module timer_source_select_and_irq_enable_test
    import timer_pkg::*;
;
    logic        clock;
    logic        reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        low_speed_mode;
    logic        main_osc_in;
    logic        sub_osc_in;
    logic [1:0]  pin_level;
    wire  [1:0]  pin_wire;
    wire  [1:0]  pin_out;
    wire  [1:0]  pin_oe;
    logic [3:0]  timer_irq_req;
    logic [7:0]  interrupt_enable_one;
    int          err_count;
    int          num_checks;
    int          seed;
    int          span_cnt [4] = '{0, 0, 0, 0};
    int          last_span [4] = '{0, 0, 0, 0};
    int          pulse_num [4] = '{0, 0, 0, 0};

    timer_source_select_and_irq_enable i_dut (
        .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .low_speed_mode(low_speed_mode), .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in),
        .timer_x_io_pin_in(pin_wire[0]), .timer_x_io_pin_out(pin_out[0]),
        .timer_x_io_pin_oe(pin_oe[0]), .timer_y_io_pin_in(pin_wire[1]),
        .timer_y_io_pin_out(pin_out[1]), .timer_y_io_pin_oe(pin_oe[1]),
        .timer_irq_req(timer_irq_req), .interrupt_enable_one(interrupt_enable_one));

    timer_pin_source i_src (
        .x_level(pin_level[0]), .y_level(pin_level[1]), .x_out(pin_out[0]),
        .x_oe(pin_oe[0]), .y_out(pin_out[1]), .y_oe(pin_oe[1]), .main_osc(main_osc_in),
        .sub_osc(sub_osc_in), .x_wire(pin_wire[0]), .y_wire(pin_wire[1]));

    // system clock, 100 ns period
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // cycles between successive underflow pulses of each channel
    always @(posedge clock)
    begin
        for (int c = 0; c < 4; c++)
        begin
            if (timer_irq_req[c] === 1'b1)
            begin
                last_span[c] <= span_cnt[c] + 1;
                span_cnt[c]  <= 0;
                pulse_num[c] <= pulse_num[c] + 1;
            end
            else
                span_cnt[c] <= span_cnt[c] + 1;
        end
    end

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_pin(input logic got, input logic exp);
        check_reg({31'h0, got}, {31'h0, exp});
    endtask : check_pin

    task automatic check_span(input int got, input int exp);
        check_reg(32'(got), 32'(exp));
    endtask : check_span

    task automatic complete_run();
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // model of the underflow spacing: ticks per period times source period in clocks
    function automatic int span_model(input int ch, input logic [2:0] s, input logic lsm,
                                      input int lat);
        int p;
        p = lsm ? 6 : 4;
        if (ch < 2)
            return (lat + 1) * (s[ch] ? 2 : 16) * p;
        return (lat + 1) * (s[2] ? 6 : 16 * p);
    endfunction : span_model

    // one ahb-lite single transfer; read data taken at the data phase's ready edge
    task automatic bus_cycle(input logic [7:0] idx, input logic wr, input logic [31:0] data,
                             output logic [31:0] rdata);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= data;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rdata = hrdata;
        check_pin(hresp, 1'b0);
    endtask : bus_cycle

    task automatic bus_write(input logic [7:0] idx, input logic [31:0] data);
        logic [31:0] d;
        bus_cycle(idx, 1'b1, data, d);
    endtask : bus_write

    task automatic read_check(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus_cycle(idx, 1'b0, 32'h0, d);
        check_reg(d, exp);
    endtask : read_check

    task automatic drive_pin(input int ch, input logic lvl);
        @(posedge clock);
        pin_level[ch] <= lvl;
        repeat (5) @(posedge clock);
    endtask : drive_pin

    task automatic apply_reset();
        @(posedge clock);
        reset <= 1'b1;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
    endtask : apply_reset

    // main sequence
    initial
    begin
        logic [31:0] d;
        logic [7:0]  v;
        logic [7:0]  tidx [4];
        logic        lvl;
        int          lat [4];
        int          base [4];
        int          cfg, ch, e, k, i, n;
        tidx = '{`IDX_TIMER_X, `IDX_TIMER_Y, `IDX_TIMER_1, `IDX_TIMER_2};
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        low_speed_mode = 1'b0;
        pin_level = 2'b00;
        err_count = 0;
        num_checks = 0;
        seed = 32'h508c;
        apply_reset();
        @(negedge clock);
        check_reg({20'h0, interrupt_enable_one, timer_irq_req}, 32'h0);
        check_reg({28'h0, pin_oe, pin_out}, 32'h3);
        read_check(`IDX_SRC_SELECT, 32'h0);
        read_check(`IDX_IRQ_ENABLE_ONE, 32'h0);
        read_check(`IDX_MODE_CTRL, 32'h0);
        // random register traffic, unmapped places among it
        for (k = 0; k < 6; k++)
        begin
            d = $random(seed);
            bus_write(`IDX_IRQ_ENABLE_ONE, d);
            read_check(`IDX_IRQ_ENABLE_ONE, {24'h0, d[7:0]});
            check_reg({24'h0, interrupt_enable_one}, {24'h0, d[7:0]});
            d = $random(seed);
            bus_write(`IDX_SRC_SELECT, d);
            read_check(`IDX_SRC_SELECT, {29'h0, d[2:0]});
            v = {3'h0, d[4:0]};
            bus_write(v, $random(seed));
            read_check(v, 32'h0);
        end
        apply_reset();
        read_check(`IDX_SRC_SELECT, 32'h0);
        // every source choice in both speed modes, random reload values
        for (cfg = 0; cfg < 16; cfg++)
        begin
            @(posedge clock);
            low_speed_mode <= cfg[3];
            bus_write(`IDX_SRC_SELECT, {29'h0, cfg[2:0]});
            for (ch = 0; ch < 4; ch++)
            begin
                lat[ch] = $random(seed) & 3;
                bus_write(tidx[ch], 32'(lat[ch]));
                base[ch] = pulse_num[ch];
            end
            for (ch = 0; ch < 4; ch++)
            begin
                for (i = 0; pulse_num[ch] < base[ch] + 3 && i < 2000; i++)
                    @(posedge clock);
                check_pin(i < 2000, 1'b1);
                check_span(last_span[ch], span_model(ch, cfg[2:0], cfg[3], lat[ch]));
            end
        end
        // sticky requests: all set; stopped x and y clear, running timers 1/2 stay set
        read_check(`IDX_REQ_STATUS, 32'hf);
        bus_write(`IDX_MODE_CTRL, 32'h88);
        bus_write(`IDX_REQ_STATUS, 32'h3);
        read_check(`IDX_REQ_STATUS, 32'hc);
        // pulse output: start level while stopped, then a toggle per underflow
        @(posedge clock);
        low_speed_mode <= 1'b0;
        bus_write(`IDX_SRC_SELECT, 32'h3);
        for (k = 0; k < 4; k++)
        begin
            ch = k % 2;
            e = k / 2;
            v = {4'h0, 1'b1, e[0], 2'b01};
            if (ch == 1)
                v = {v[3:0], 4'h0};
            bus_write(`IDX_MODE_CTRL, {24'h0, v});
            bus_write(tidx[ch], 32'h2);
            repeat (30) @(posedge clock);
            read_check(tidx[ch], 32'h2);
            @(negedge clock);
            check_pin(pin_oe[ch], 1'b1);
            check_pin(pin_wire[ch], ~e[0]);
            lvl = ~e[0];
            bus_write(`IDX_MODE_CTRL, {24'h0, v & 8'h77});
            for (i = 0; i < 3; i++)
            begin
                @(negedge clock);
                for (n = 0; timer_irq_req[ch] !== 1'b1 && n < 500; n++)
                    @(negedge clock);
                check_pin(n < 500, 1'b1);
                repeat (2) @(negedge clock);
                lvl = ~lvl;
                check_pin(pin_wire[ch], lvl);
            end
        end
        // event counting: n+1 rising and n falling edges on the pin
        for (k = 0; k < 4; k++)
        begin
            ch = k % 2;
            e = k / 2;
            drive_pin(ch, 1'b0);
            v = {4'h0, 1'b0, e[0], 2'b10};
            if (ch == 1)
                v = {v[3:0], 4'h0};
            bus_write(`IDX_MODE_CTRL, {24'h0, v});
            bus_write(tidx[ch], 32'd20);
            n = 1 + ($random(seed) & 3);
            for (i = 0; i <= n; i++)
            begin
                drive_pin(ch, 1'b1);
                if (i < n)
                    drive_pin(ch, 1'b0);
            end
            read_check(tidx[ch], 32'(20 - n - 1 + e));
        end
        // width measure: idle level holds the count, 80 active clocks give ten /2 ticks
        bus_write(`IDX_SRC_SELECT, 32'h1);
        for (e = 0; e < 2; e++)
        begin
            drive_pin(0, e[0]);
            bus_write(`IDX_MODE_CTRL, {28'h0, 1'b0, e[0], 2'b11});
            bus_write(`IDX_TIMER_X, 32'd200);
            repeat (80) @(posedge clock);
            read_check(`IDX_TIMER_X, 32'd200);
            drive_pin(0, ~e[0]);
            repeat (75) @(posedge clock);
            drive_pin(0, e[0]);
            bus_cycle(`IDX_TIMER_X, 1'b0, 32'h0, d);
            check_pin(d >= 32'd189 && d <= 32'd191, 1'b1);
        end
        complete_run();
    end

    // hang guard, several times the expected run length
    initial
    begin
        repeat (50000) @(posedge clock);
        err_count++;
        complete_run();
    end
endmodule : timer_source_select_and_irq_enable_test
